// file: design/serial_remote_local_control.sv
// Operation
// - The bit rate is one of 1200, 2400, 4800 or 9600 baud and reads back.
// - A flow-control setting selects no handshake or RTS/CTS handshake and only changes what RTS and CTS show.
// - In handshake mode RTS is high only while the input buffer can take a character.
// - In handshake mode CTS is high exactly while a character is being sent.
// - Without handshake RTS stays high and an input overflow reports error 181.
// - Without handshake CTS reads high and output is sent without waiting.
// - DTR always follows DSR.
// - The remote-enable message enters remote state, lights the indicator and locks the panel except the local key.
// - Entering remote state aborts the measurement and selects single trigger.
// - The local-lockout message also disables the local key.
// - Go-to-local, an unlocked local key or a power cycle returns to local state.
// - Back in local state the panel is enabled and the indicator is dark.
// - In local state only the identify, status and error commands run, any other raises error 132.
// - Status queries are answered in either state.
`timescale 1ns/1ps
`default_nettype none
module serial_remote_local_control
	import remote_local_pkg::*;
#(
	parameter int RX_DEPTH = 16
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] address,
	input wire logic [7:0] write_data,
	input wire logic write_strobe,
	input wire logic read_strobe,
	output logic [7:0] read_data,
	input wire logic rx_char_valid,
	input wire logic rx_char_take,
	input wire logic tx_pending,
	input wire logic rx_busy,
	input wire logic local_key,
	input wire logic dsr,
	output logic rts,
	output logic cts,
	output logic dtr,
	output logic tx_active,
	output logic bit_tick,
	output logic remote_indicator,
	output logic panel_enable,
	output logic measure_abort,
	output logic single_trigger,
	output logic command_accept,
	output logic error_valid,
	output logic [7:0] error_code,
	output logic irq
);

	localparam int FILL_W = $clog2(RX_DEPTH + 1);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed
	{
		link_cfg_s staged;
		link_cfg_s active;
		logic apply_pending;
		control_e ctrl;
		logic [FILL_W-1:0] fill;
		logic tx_active;
		logic measure_abort;
		logic single_trigger;
		logic command_accept;
		logic error_valid;
		logic [7:0] error_code;
		logic [EV_WIDTH-1:0] status;
		logic [EV_WIDTH-1:0] mask;
		logic [7:0] read_data;
	} state_s;

	state_s state;
	state_s next_state;
	logic allowed_in_local;
	logic tick;
	logic buffer_room;
	logic remote;

	rate_tick tick_gen
	(
		.clock(clock),
		.rst(rst),
		.cfg(state.active),
		.tick(tick)
	);

	command_filter filter
	(
		.command(command_e'(write_data[3:0])),
		.allowed_in_local(allowed_in_local)
	);

	assign remote = state.ctrl != CTRL_LOCAL;
	assign buffer_room = state.fill < FILL_W'(RX_DEPTH);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		logic [EV_WIDTH-1:0] events;
		logic overflow;
		events = '0;
		overflow = 1'b0;
		next_state = state;
		next_state.measure_abort = 1'b0;
		next_state.command_accept = 1'b0;
		next_state.error_valid = 1'b0;

		// Staged settings move to the link only between characters.
		if (state.apply_pending && !rx_busy && !tx_pending && !state.tx_active)
		begin
			next_state.active = state.staged;
			next_state.apply_pending = 1'b0;
		end

		// Transmit activity follows queued output; handshake only reports it on CTS.
		next_state.tx_active = tx_pending;

		// Input buffer occupancy, overflow when a character finds it full.
		if (rx_char_valid && !buffer_room)
		begin
			overflow = 1'b1;
		end
		if (rx_char_valid && buffer_room && !(rx_char_take && state.fill != '0))
			next_state.fill = state.fill + FILL_W'(1);
		else if (rx_char_take && state.fill != '0 && !(rx_char_valid && buffer_room))
			next_state.fill = state.fill - FILL_W'(1);

		// Front-panel local key returns to local unless locked out.
		if (local_key && state.ctrl == CTRL_REMOTE)
		begin
			next_state.ctrl = CTRL_LOCAL;
			events[EV_TO_LOCAL] = 1'b1;
		end

		// Register writes.
		if (write_strobe)
		begin
			case (address)
				ADDR_LINK_CFG:
				begin
					next_state.staged.rate = bit_rate_e'(write_data[CFG_RATE_LSB +: 2]);
					next_state.staged.handshake = write_data[CFG_HANDSHAKE_BIT];
				end
				ADDR_LINK_APPLY:
					next_state.apply_pending = write_data[0];
				ADDR_MESSAGE:
				begin
					if (write_data[MSG_GTL_BIT])
					begin
						next_state.ctrl = CTRL_LOCAL;
						if (remote)
							events[EV_TO_LOCAL] = 1'b1;
					end
					else if (write_data[MSG_LLO_BIT])
					begin
						next_state.ctrl = CTRL_LOCKOUT;
						if (!remote)
						begin
							next_state.measure_abort = 1'b1;
							next_state.single_trigger = 1'b1;
							events[EV_TO_REMOTE] = 1'b1;
						end
					end
					else if (write_data[MSG_REN_BIT] && !remote)
					begin
						next_state.ctrl = CTRL_REMOTE;
						next_state.measure_abort = 1'b1;
						next_state.single_trigger = 1'b1;
						events[EV_TO_REMOTE] = 1'b1;
					end
				end
				ADDR_COMMAND:
				begin
					if (remote || allowed_in_local)
					begin
						next_state.command_accept = 1'b1;
						if (write_data[3:0] == 4'(CMD_CLEAR_STATUS))
							next_state.status = '0;
					end
					else
					begin
						next_state.error_valid = 1'b1;
						next_state.error_code = ERR_REFUSED_IN_LOCAL;
						events[EV_REFUSED] = 1'b1;
					end
				end
				ADDR_IRQ_MASK:
					next_state.mask = write_data[EV_WIDTH-1:0];
				default:
				begin
				end
			endcase
		end

		// Overflow error takes the error port over a refusal in the same cycle.
		if (overflow)
		begin
			next_state.error_valid = 1'b1;
			next_state.error_code = ERR_INPUT_FULL;
			events[EV_OVERFLOW] = 1'b1;
		end

		// Register reads; unmapped addresses read zero.
		case (address)
			ADDR_LINK_CFG: next_state.read_data = {5'h00, state.staged.handshake, state.staged.rate};
			ADDR_LINK_APPLY: next_state.read_data = {4'h0, state.active.handshake, state.active.rate, state.apply_pending};
			ADDR_CONTROL_STATE: next_state.read_data = {6'h00, state.ctrl};
			ADDR_VERDICT: next_state.read_data = state.error_code;
			ADDR_IRQ_STATUS: next_state.read_data = 8'(state.status);
			ADDR_IRQ_MASK: next_state.read_data = 8'(state.mask);
			ADDR_RX_FILL: next_state.read_data = 8'(state.fill);
			default: next_state.read_data = 8'h00;
		endcase

		// Reading status clears it, but a new event in that cycle survives.
		if (read_strobe && address == ADDR_IRQ_STATUS)
			next_state.status = events;
		else
			next_state.status = next_state.status | events;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state <= '0;
			state.staged <= '{handshake: HANDSHAKE_RESET, rate: bit_rate_e'(RATE_RESET)};
			state.active <= '{handshake: HANDSHAKE_RESET, rate: bit_rate_e'(RATE_RESET)};
			state.ctrl <= CTRL_LOCAL;
		end
		else
		begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rts = state.active.handshake ? buffer_room : 1'b1;
	assign cts = state.active.handshake ? state.tx_active : 1'b1;
	assign dtr = dsr;
	assign tx_active = state.tx_active;
	assign bit_tick = tick;
	assign remote_indicator = remote;
	assign panel_enable = !remote;
	assign measure_abort = state.measure_abort;
	assign single_trigger = state.single_trigger;
	assign command_accept = state.command_accept;
	assign error_valid = state.error_valid;
	assign error_code = state.error_code;
	assign read_data = state.read_data;
	assign irq = |(state.status & state.mask);

endmodule
`default_nettype wire

// file: design/remote_local_pkg.sv
package remote_local_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_LINK_CFG = 4'h0;
	localparam logic [3:0] ADDR_LINK_APPLY = 4'h1;
	localparam logic [3:0] ADDR_CONTROL_STATE = 4'h2;
	localparam logic [3:0] ADDR_MESSAGE = 4'h3;
	localparam logic [3:0] ADDR_COMMAND = 4'h4;
	localparam logic [3:0] ADDR_VERDICT = 4'h5;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
	localparam logic [3:0] ADDR_RX_FILL = 4'h8;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CFG_RATE_LSB = 0;
	localparam int CFG_HANDSHAKE_BIT = 2;
	localparam logic [1:0] RATE_RESET = 2'h3;
	localparam logic HANDSHAKE_RESET = 1'b0;
	localparam int MSG_REN_BIT = 0;
	localparam int MSG_LLO_BIT = 1;
	localparam int MSG_GTL_BIT = 2;
	localparam int EV_OVERFLOW = 0;
	localparam int EV_REFUSED = 1;
	localparam int EV_TO_REMOTE = 2;
	localparam int EV_TO_LOCAL = 3;
	localparam int EV_WIDTH = 4;

	// ------------------------------------------------------------
	// Error codes and timing
	// ------------------------------------------------------------
	localparam logic [7:0] ERR_INPUT_FULL = 8'hb5;
	localparam logic [7:0] ERR_REFUSED_IN_LOCAL = 8'h84;
	localparam int CLOCK_HZ = 10_000_000;
	localparam int OVERSAMPLE = 16;

	// Bit rates selectable by the operator.
	typedef enum logic [1:0]
	{
		RATE_1200 = 2'h0,
		RATE_2400 = 2'h1,
		RATE_4800 = 2'h2,
		RATE_9600 = 2'h3
	} bit_rate_e;

	// Classes of decoded host commands.
	typedef enum logic [3:0]
	{
		CMD_IDENTIFY = 4'h0,
		CMD_CLEAR_STATUS = 4'h1,
		CMD_EVENT_STATUS_QUERY = 4'h2,
		CMD_EVENT_ENABLE = 4'h3,
		CMD_EVENT_ENABLE_QUERY = 4'h4,
		CMD_STATUS_BYTE_QUERY = 4'h5,
		CMD_SERVICE_ENABLE = 4'h6,
		CMD_SERVICE_ENABLE_QUERY = 4'h7,
		CMD_ERROR_QUERY = 4'h8,
		CMD_DEVICE_ERROR_QUERY = 4'h9,
		CMD_OTHER = 4'hf
	} command_e;

	// Remote and local control states.
	typedef enum logic [1:0]
	{
		CTRL_LOCAL = 2'b00,
		CTRL_REMOTE = 2'b01,
		CTRL_LOCKOUT = 2'b11
	} control_e;

	// Link configuration as one carrier.
	typedef struct packed
	{
		logic handshake;
		bit_rate_e rate;
	} link_cfg_s;

	// Baud divider: clock cycles per oversample tick.
	function automatic logic [15:0] tick_divisor(input bit_rate_e rate);
		int baud;
		baud = 1200 << rate;
		tick_divisor = 16'(CLOCK_HZ / (baud * OVERSAMPLE));
	endfunction

endpackage

// file: design/rate_tick.sv
`timescale 1ns/1ps
`default_nettype none
module rate_tick
	import remote_local_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire link_cfg_s cfg,
	output logic tick
);

	typedef struct packed
	{
		logic [15:0] count;
		logic tick;
	} state_s;

	state_s state;
	state_s next_state;

	// Counts down the divisor for the active bit rate, one pulse per wrap.
	always_comb
	begin
		next_state = state;
		next_state.tick = 1'b0;
		if (state.count == 16'h0000)
		begin
			next_state.count = tick_divisor(cfg.rate) - 16'h0001;
			next_state.tick = 1'b1;
		end
		else
		begin
			next_state.count = state.count - 16'h0001;
		end
	end

	// Registers the divider.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			state <= '0;
		else
			state <= next_state;
	end

	assign tick = state.tick;

endmodule
`default_nettype wire

// file: design/command_filter.sv
`timescale 1ns/1ps
`default_nettype none
module command_filter
	import remote_local_pkg::*;
(
	input wire command_e command,
	output logic allowed_in_local
);

	// Status, identity and error queries pass even in local state.
	always_comb
	begin
		case (command)
			CMD_IDENTIFY, CMD_CLEAR_STATUS, CMD_EVENT_STATUS_QUERY, CMD_EVENT_ENABLE,
			CMD_EVENT_ENABLE_QUERY, CMD_STATUS_BYTE_QUERY, CMD_SERVICE_ENABLE,
			CMD_SERVICE_ENABLE_QUERY, CMD_ERROR_QUERY, CMD_DEVICE_ERROR_QUERY:
				allowed_in_local = 1'b1;
			default:
				allowed_in_local = 1'b0;
		endcase
	end

endmodule
`default_nettype wire

// file: tb/remote_local_properties.sv
`timescale 1ns/1ps
`default_nettype none
module remote_local_checker
	import remote_local_pkg::*;
#(
	parameter int RX_DEPTH = 16
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] address,
	input wire logic [7:0] write_data,
	input wire logic write_strobe,
	input wire logic read_strobe,
	input wire logic [7:0] read_data,
	input wire logic rx_char_valid,
	input wire logic dsr,
	input wire logic dtr,
	input wire logic cts,
	input wire logic tx_active,
	input wire logic remote_indicator,
	input wire logic panel_enable,
	input wire logic single_trigger,
	input wire logic measure_abort,
	input wire logic command_accept,
	input wire logic error_valid,
	input wire logic [7:0] error_code
);
	// ------------------------------------------------------------
	// Port relations
	// ------------------------------------------------------------
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);

	a_dtr_follows_dsr: assert property (dtr == dsr)
		else $error("dtr differs from dsr");
	a_cts_while_sending: assert property (tx_active |-> cts)
		else $error("cts low while sending");
	a_panel_vs_indicator: assert property (panel_enable != remote_indicator)
		else $error("panel and indicator agree");
	a_remote_sets_trigger: assert property ($rose(remote_indicator) |-> ##[0:1] single_trigger)
		else $error("single trigger not set in remote");
	a_remote_aborts: assert property ($rose(remote_indicator) |-> measure_abort)
		else $error("measurement not aborted on entering remote");
	a_trigger_stays: assert property (single_trigger |=> single_trigger)
		else $error("single trigger dropped");
	a_local_refuses: assert property (write_strobe && address == ADDR_COMMAND && write_data[3:0] > 4'h9
		&& !remote_indicator && !rx_char_valid |=> error_valid && error_code == ERR_REFUSED_IN_LOCAL)
		else $error("command not refused in local");
	a_allowed_runs: assert property (write_strobe && address == ADDR_COMMAND && write_data[3:0] <= 4'h9
		|=> command_accept)
		else $error("allowed command not accepted");
	a_unmapped_zero: assert property (read_strobe && address > ADDR_RX_FILL |=> read_data == 8'h00)
		else $error("unmapped read not zero");

	c_overflow: cover property (error_valid && error_code == ERR_INPUT_FULL);
	c_refused: cover property (error_valid && error_code == ERR_REFUSED_IN_LOCAL);
	c_remote: cover property ($rose(remote_indicator));
endmodule

bind serial_remote_local_control remote_local_checker #(.RX_DEPTH(RX_DEPTH)) remote_local_checker_inst (
	.clock(clock), .rst(rst), .address(address), .write_data(write_data), .write_strobe(write_strobe),
	.read_strobe(read_strobe), .read_data(read_data), .rx_char_valid(rx_char_valid), .dsr(dsr), .dtr(dtr),
	.cts(cts), .tx_active(tx_active), .remote_indicator(remote_indicator), .panel_enable(panel_enable),
	.single_trigger(single_trigger), .measure_abort(measure_abort), .command_accept(command_accept),
	.error_valid(error_valid),
	.error_code(error_code));
`default_nettype wire

// file: tb/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model
#(
	parameter int GAP = 3
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic rts,
	input wire logic honour,
	input wire logic go,
	output logic rx_char_valid
);
	int phase;

	// Sends one character every GAP cycles; a polite host holds off while RTS is low.
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			phase <= 0;
			rx_char_valid <= 1'b0;
		end
		else
		begin
			phase <= (phase + 1) % GAP;
			rx_char_valid <= go && phase == 0 && (rts || !honour);
		end
	end
endmodule
`default_nettype wire

// file: tb/test_serial_remote_local_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_remote_local_control
	import remote_local_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [3:0] address = 4'h0;
	logic [7:0] write_data = 8'h00;
	logic write_strobe = 1'b0;
	logic read_strobe = 1'b0;
	logic rx_char_take = 1'b0;
	logic tx_pending = 1'b0;
	logic rx_busy = 1'b0;
	logic local_key = 1'b0;
	logic dsr = 1'b0;
	logic honour = 1'b0;
	logic go = 1'b0;
	logic [7:0] read_data;
	logic [7:0] error_code;
	logic rx_char_valid, rts, cts, dtr, tx_active, bit_tick, remote_indicator, panel_enable;
	logic measure_abort, single_trigger, command_accept, error_valid, irq;
	int mismatches = 0;
	int checks = 0;
	int count = 0;
	int gap = 0;

	// ------------------------------------------------------------
	// Design, host and clock
	// ------------------------------------------------------------
	serial_remote_local_control #(.RX_DEPTH(2)) serial_remote_local_control_inst (
		.clock(clock), .rst(rst), .address(address), .write_data(write_data), .write_strobe(write_strobe),
		.read_strobe(read_strobe), .read_data(read_data), .rx_char_valid(rx_char_valid),
		.rx_char_take(rx_char_take), .tx_pending(tx_pending), .rx_busy(rx_busy), .local_key(local_key),
		.dsr(dsr), .rts(rts), .cts(cts), .dtr(dtr), .tx_active(tx_active), .bit_tick(bit_tick),
		.remote_indicator(remote_indicator), .panel_enable(panel_enable), .measure_abort(measure_abort),
		.single_trigger(single_trigger), .command_accept(command_accept), .error_valid(error_valid),
		.error_code(error_code), .irq(irq));
	host_link_model host_link_model_inst (.clock(clock), .rst(rst), .rts(rts), .honour(honour), .go(go),
		.rx_char_valid(rx_char_valid));

	// The clock toggles every half period; the tick spacing is measured in cycles.
	always #50 clock = ~clock;
	always @(posedge clock) count <= bit_tick ? 1 : count + 1;
	always @(posedge clock) if (bit_tick) gap <= count;

	// ------------------------------------------------------------
	// Bus tasks and verdict
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clock);
		read_strobe <= 1'b0;
		#1;
		chk(16'(read_data), 16'(exp));
	endtask

	task automatic pulse_key();
		@(posedge clock);
		local_key <= 1'b1;
		@(posedge clock);
		local_key <= 1'b0;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// A hang counts as a mismatch.
	initial
	begin
		repeat (40000) @(posedge clock);
		mismatches++;
		test_done();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		dsr <= 1'b1;
		#1;
		chk(16'({rts, cts, remote_indicator, panel_enable, irq, dtr}), 16'h35);
		rd(ADDR_LINK_CFG, 8'h03);
		rd(4'hc, 8'h00);
		for (int r = 0; r < 4; r++)
		begin
			wr(ADDR_LINK_CFG, 8'(r));
			rd(ADDR_LINK_CFG, 8'(r));
			wr(ADDR_LINK_APPLY, 8'h01);
			rd(ADDR_LINK_APPLY, 8'(r << 1));
			repeat (3 * (CLOCK_HZ / ((1200 << r) * OVERSAMPLE))) @(posedge clock);
			chk(16'(gap), 16'(CLOCK_HZ / ((1200 << r) * OVERSAMPLE)));
		end
		// A confirmation during reception waits for the line to go idle.
		rx_busy <= 1'b1;
		wr(ADDR_LINK_CFG, 8'h00);
		wr(ADDR_LINK_APPLY, 8'h01);
		rd(ADDR_LINK_APPLY, 8'h07);
		rx_busy <= 1'b0;
		repeat (2) @(posedge clock);
		rd(ADDR_LINK_APPLY, 8'h00);
		// Handshake: the host fills the buffer until RTS falls.
		wr(ADDR_LINK_CFG, 8'h07);
		wr(ADDR_LINK_APPLY, 8'h01);
		honour <= 1'b1;
		go <= 1'b1;
		repeat (20) @(posedge clock);
		#1;
		chk(16'(rts), 16'h0);
		rd(ADDR_RX_FILL, 8'h02);
		rx_char_take <= 1'b1;
		@(posedge clock);
		rx_char_take <= 1'b0;
		go <= 1'b0;
		#1;
		chk(16'(rts), 16'h1);
		tx_pending <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		chk(16'(cts), 16'h1);
		tx_pending <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk(16'(cts), 16'h0);
		// No handshake: a rude host overflows the buffer.
		wr(ADDR_LINK_CFG, 8'h03);
		wr(ADDR_LINK_APPLY, 8'h01);
		wr(ADDR_IRQ_MASK, 8'h01);
		rd(ADDR_IRQ_STATUS, 8'h00);
		honour <= 1'b0;
		go <= 1'b1;
		repeat (20) @(posedge clock);
		go <= 1'b0;
		repeat (4) @(posedge clock);
		#1;
		chk(16'({rts, cts, irq, error_code}), 16'h7b5);
		rd(ADDR_IRQ_STATUS, 8'h01);
		rd(ADDR_IRQ_STATUS, 8'h00);
		chk(16'(irq), 16'h0);
		// Remote, local key, lockout and go-to-local.
		wr(ADDR_MESSAGE, 8'h01);
		chk(16'({remote_indicator, panel_enable, single_trigger, measure_abort}), 16'hb);
		wr(ADDR_COMMAND, 8'h0f);
		chk(16'({command_accept, error_valid, measure_abort}), 16'h4);
		pulse_key();
		rd(ADDR_CONTROL_STATE, 8'h00);
		chk(16'({remote_indicator, panel_enable}), 16'h1);
		wr(ADDR_MESSAGE, 8'h01);
		wr(ADDR_MESSAGE, 8'h02);
		pulse_key();
		rd(ADDR_CONTROL_STATE, 8'h03);
		wr(ADDR_MESSAGE, 8'h04);
		rd(ADDR_CONTROL_STATE, 8'h00);
		rd(ADDR_IRQ_STATUS, 8'h0c);
		// Local state: identify, status and error commands run, others are refused.
		for (int c = 0; c < 10; c++)
		begin
			wr(ADDR_COMMAND, 8'(c));
			chk(16'({command_accept, error_valid}), 16'h2);
		end
		wr(ADDR_COMMAND, 8'h0f);
		chk(16'({irq, command_accept, error_valid, error_code}), 16'h184);
		rd(ADDR_IRQ_STATUS, 8'h02);
		rd(ADDR_VERDICT, 8'h84);
		test_done();
	end
endmodule
`default_nettype wire
